/* design/l1b_pkg.sv */
// Purpose: shared constants for the layer-1 bus power and command block
// Assumes: 10 MHz system clock, 8-bit register port with 4-bit address
// Notes:   command and indication codes are 4-bit field values
package l1b_pkg;
   // -------------------------------------------------------------------
   // clock and timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned RESTART_TIME_US  = 200;
   localparam int unsigned RESTART_CYCLES   = RESTART_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CONT_PULSE_HZ    = 96_000;
   localparam int unsigned SINGLE_PULSE_HZ  = 2_000;
   localparam int unsigned CONT_PERIOD      = CLK_HZ / CONT_PULSE_HZ;
   localparam int unsigned SINGLE_PERIOD    = CLK_HZ / SINGLE_PULSE_HZ;
   localparam int unsigned BCLK_HALF        = 4;
   localparam int unsigned FRAME_BITS       = 32;
   localparam int unsigned CI0_FIRST        = 26;
   localparam int unsigned CI0_LAST         = 29;
   localparam int unsigned DEACT_FRAMES     = 4;
   localparam int unsigned TIMING_LOST      = 64;

   // -------------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------------
   localparam logic [3:0] REG_CTRL        = 4'h0;
   localparam logic [3:0] REG_CI_TX       = 4'h1;
   localparam logic [3:0] REG_CI_RX       = 4'h2;
   localparam logic [3:0] REG_IRQ_STATUS  = 4'h3;
   localparam logic [3:0] REG_MASK        = 4'h4;
   localparam logic [3:0] REG_TEST_STATUS = 4'h5;

   // ctrl fields
   localparam int unsigned CTRL_CFS  = 0;
   localparam int unsigned CTRL_SPU  = 1;
   localparam int unsigned CTRL_BMS  = 2;
   localparam int unsigned CTRL_MODE = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] CI_TX_RESET = 4'hF;
   localparam logic       MASK_RESET = 1'b0;

   // operating modes in ctrl[4:3]
   localparam logic [1:0] MODE_TE   = 2'h0;
   localparam logic [1:0] MODE_NT   = 2'h1;
   localparam logic [1:0] MODE_LT_T = 2'h2;
   localparam logic [1:0] MODE_LT_S = 2'h3;

   // -------------------------------------------------------------------
   // commands (software to layer 1)
   // -------------------------------------------------------------------
   localparam logic [3:0] CMD_CLOCK_REQUEST = 4'h0;
   localparam logic [3:0] CMD_RESET         = 4'h1;
   localparam logic [3:0] CMD_SINGLE_ZEROS  = 4'h2;
   localparam logic [3:0] CMD_CONT_ZEROS    = 4'h4;
   localparam logic [3:0] CMD_ACT_PRIO8     = 4'h8;
   localparam logic [3:0] CMD_ACT_PRIO10    = 4'h9;
   localparam logic [3:0] CMD_ACT_LOOP3     = 4'hA;
   localparam logic [3:0] CMD_DEACT_UP      = 4'hF;

   // indications (layer 1 to software)
   localparam logic [3:0] IND_ERROR         = 4'h6;
   localparam logic [3:0] IND_POWERED_UP    = 4'h7;
   localparam logic [3:0] IND_TEST          = 4'hA;
   localparam logic [3:0] IND_ACT_PRIO8     = 4'hC;
   localparam logic [3:0] IND_ACT_PRIO10    = 4'hD;
   localparam logic [3:0] IND_DEACT_DOWN    = 4'hF;

   typedef enum logic [1:0] {
      PWR_ACTIVE  = 2'b00,
      PWR_DEACT   = 2'b01,
      PWR_DOWN    = 2'b11,
      PWR_RESTART = 2'b10
   } l1b_pwr_e;
endpackage : l1b_pkg

/* design/l1b_sync.sv */
// Purpose: two-stage synchroniser with rising-edge pulse
// Assumes: d is asynchronous to clk
// Notes:   edge detect looks only at the second stage and later
`timescale 1ns/100ps
module l1b_sync (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic d,
   output logic      q,
   output logic      rise
);
   logic meta;
   logic q_d;

   // -------------------------------------------------------------------
   // synchroniser
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= 1'b0;
         q    <= 1'b0;
         q_d  <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
         q_d  <= q;
      end
   end

   assign rise = q & ~q_d;
endmodule : l1b_sync

/* design/l1b_core.sv */
// Purpose: bus timing power control and command field decode for layer 1
// Assumes: one 10 MHz clock; external bus clocks are sampled, not clocked on
// Notes:   terminal mode makes bit_clock by division, other modes take it in
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module l1b_core #(
   parameter int unsigned RESTART_CYCLES = l1b_pkg::RESTART_CYCLES,
   parameter int unsigned SINGLE_PERIOD  = l1b_pkg::SINGLE_PERIOD,
   parameter int unsigned CONT_PERIOD    = l1b_pkg::CONT_PERIOD
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       bit_clock_in,
   input  wire logic       frame_sync_in,
   input  wire logic       line_signal,
   output logic            bit_clock,
   output logic            frame_sync,
   output logic            bus_clock_drive,
   output logic            upstream_data_line,
   output logic            downstream_data_line,
   output logic            irq_line_out,
   output logic            irq_line_oe_b,
   output logic            osc_enable,
   output logic            line_pulse_pos,
   output logic            line_pulse_neg,
   output logic            loop3_active,
   output logic            bchan_enable
);
   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   typedef l1b_pkg::l1b_pwr_e l1b_pwr_state_t;

   logic              clock_off_select;
   logic              software_power_up;
   logic              bus_mode_select;
   logic [1:0]        op_mode;
   logic [3:0]        ci_transmit_register;
   logic [3:0]        ci_receive_register;
   logic              ci_sq_change_irq;
   logic              irq_mask;
   l1b_pwr_state_t    pwr_state;
   logic [11:0]       restart_cnt;
   logic [2:0]        deact_cnt;
   logic [3:0]        div_cnt;
   logic [3:0]        next_div;
   logic [4:0]        bit_idx;
   logic [4:0]        next_idx;
   logic [6:0]        lost_cnt;
   logic              bclk_q;
   logic              bclk_rise;
   logic              fsync_q;
   logic              line_q;
   logic              te_mode;
   logic              clk_run;
   logic              rise;
   logic              ci0_end;
   logic              timing_present;
   logic              nt_request;
   logic              act_req;
   logic              prio10;
   logic              cont_pulses;
   logic              single_pulses;
   logic              sw_reset;
   logic              activated;
   logic [3:0]        indication;
   logic [12:0]       pulse_cnt;
   logic              pulse_phase;
   logic              ci_sq_change_irq_pending;
   logic              rd_ci_rx;
   logic              stop_now;
   logic              bus_stopped;

   assign te_mode  = (op_mode == l1b_pkg::MODE_TE);
   assign rd_ci_rx = rd_en && (addr == l1b_pkg::REG_CI_RX);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   l1b_sync u_sync_bclk (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (bit_clock_in),
      .q     (bclk_q),
      .rise  (bclk_rise)
   );

   l1b_sync u_sync_fsync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (frame_sync_in),
      .q     (fsync_q),
      .rise  ()
   );

   l1b_sync u_sync_line (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (line_signal),
      .q     (line_q),
      .rise  ()
   );

   // -------------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clock_off_select     <= l1b_pkg::CTRL_RESET[l1b_pkg::CTRL_CFS];
         software_power_up    <= l1b_pkg::CTRL_RESET[l1b_pkg::CTRL_SPU];
         bus_mode_select      <= l1b_pkg::CTRL_RESET[l1b_pkg::CTRL_BMS];
         op_mode              <= l1b_pkg::CTRL_RESET[l1b_pkg::CTRL_MODE +: 2];
         ci_transmit_register <= l1b_pkg::CI_TX_RESET;
         irq_mask             <= l1b_pkg::MASK_RESET;
      end else if (wr_en) begin
         if (addr == l1b_pkg::REG_CTRL) begin
            clock_off_select  <= wr_data[l1b_pkg::CTRL_CFS];
            software_power_up <= wr_data[l1b_pkg::CTRL_SPU];
            bus_mode_select   <= wr_data[l1b_pkg::CTRL_BMS];
            op_mode           <= wr_data[l1b_pkg::CTRL_MODE +: 2];
         end else if (addr == l1b_pkg::REG_CI_TX) begin
            ci_transmit_register <= wr_data[3:0];
         end else if (addr == l1b_pkg::REG_MASK) begin
            irq_mask <= wr_data[0];
         end
      end
   end

   // -------------------------------------------------------------------
   // bit timing: own divider in terminal mode, sampled edges otherwise
   // -------------------------------------------------------------------
   assign clk_run = te_mode && (pwr_state == l1b_pkg::PWR_ACTIVE ||
                                pwr_state == l1b_pkg::PWR_DEACT);
   assign rise    = te_mode ? (clk_run && div_cnt == 4'h0) : bclk_rise;

   always_comb begin
      next_div = 4'h0;
      if (clk_run && div_cnt != 4'((2 * l1b_pkg::BCLK_HALF) - 1)) begin
         next_div = div_cnt + 4'h1;
      end
   end

   always_comb begin
      next_idx = bit_idx;
      if (!te_mode && fsync_q) begin
         next_idx = 5'h0;
      end else if (bit_idx == 5'(l1b_pkg::FRAME_BITS - 1)) begin
         next_idx = 5'h0;
      end else begin
         next_idx = bit_idx + 5'h1;
      end
   end

   assign ci0_end = rise && (next_idx == 5'(l1b_pkg::CI0_LAST + 1));

   // the rise that would open bit 30 of the fourth frame is never shown
   assign stop_now = (pwr_state == l1b_pkg::PWR_DEACT) && ci0_end &&
                     clock_off_select &&
                     (ci_transmit_register == l1b_pkg::CMD_DEACT_UP) &&
                     (deact_cnt == 3'(l1b_pkg::DEACT_FRAMES - 1));

   // external modes keep their levels between sampled edges
   assign bus_stopped = te_mode && !clk_run;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_cnt   <= 4'h0;
         bit_clock <= 1'b0;
      end else begin
         div_cnt   <= next_div;
         // rises in the same cycle as the data update, so bits line up
         bit_clock <= clk_run && !stop_now &&
                      (div_cnt < 4'(l1b_pkg::BCLK_HALF));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bit_idx <= 5'h0;
      end else if (pwr_state == l1b_pkg::PWR_RESTART) begin
         // preset so the first rise opens the bit after the field
         bit_idx <= 5'(l1b_pkg::CI0_LAST);
      end else if (rise) begin
         bit_idx <= next_idx;
      end
   end

   // external clocks may stop; watch for their absence
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lost_cnt <= 7'(l1b_pkg::TIMING_LOST);
      end else if (bclk_rise) begin
         lost_cnt <= 7'h00;
      end else if (lost_cnt != 7'(l1b_pkg::TIMING_LOST)) begin
         lost_cnt <= lost_cnt + 7'h01;
      end
   end

   assign timing_present = (lost_cnt != 7'(l1b_pkg::TIMING_LOST));

   // -------------------------------------------------------------------
   // bus power state
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pwr_state   <= l1b_pkg::PWR_ACTIVE;
         deact_cnt   <= 3'h0;
         restart_cnt <= 12'h000;
      end else if (!te_mode) begin
         pwr_state <= l1b_pkg::PWR_ACTIVE;
      end else begin
         case (pwr_state)
            l1b_pkg::PWR_ACTIVE: begin
               deact_cnt <= 3'h0;
               // only a deactivate request (also the ci_transmit_register reset value) with clocks-off allowed
               if (ci0_end && clock_off_select &&
                   ci_transmit_register == l1b_pkg::CMD_DEACT_UP) begin
                  pwr_state <= l1b_pkg::PWR_DEACT;
               end
            end
            l1b_pkg::PWR_DEACT: begin
               if (!clock_off_select ||
                   ci_transmit_register != l1b_pkg::CMD_DEACT_UP) begin
                  pwr_state <= l1b_pkg::PWR_ACTIVE;
               end else if (ci0_end) begin
                  if (deact_cnt == 3'(l1b_pkg::DEACT_FRAMES - 1)) begin
                     pwr_state <= l1b_pkg::PWR_DOWN;
                  end
                  deact_cnt <= deact_cnt + 3'h1;
               end
            end
            l1b_pkg::PWR_DOWN: begin
               restart_cnt <= 12'h000;
               if (software_power_up || !clock_off_select || line_q ||
                   ci_transmit_register == l1b_pkg::CMD_CLOCK_REQUEST) begin
                  pwr_state <= l1b_pkg::PWR_RESTART;
               end
            end
            l1b_pkg::PWR_RESTART: begin
               // oscillator start-up time before the bus clocks resume
               if (restart_cnt == 12'(RESTART_CYCLES - 1)) begin
                  pwr_state <= l1b_pkg::PWR_ACTIVE;
               end
               restart_cnt <= restart_cnt + 12'h001;
            end
            default: pwr_state <= l1b_pkg::PWR_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         osc_enable <= 1'b1;
      end else begin
         osc_enable <= !(te_mode && pwr_state == l1b_pkg::PWR_DOWN);
      end
   end

   // network mode: terminal wants activation while no clocks arrive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nt_request <= 1'b0;
      end else begin
         nt_request <= (op_mode == l1b_pkg::MODE_NT) && line_q && !timing_present;
      end
   end

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         act_req       <= 1'b0;
         prio10        <= 1'b0;
         cont_pulses   <= 1'b0;
         single_pulses <= 1'b0;
         sw_reset      <= 1'b0;
         loop3_active  <= 1'b0;
      end else begin
         act_req       <= ci_transmit_register == l1b_pkg::CMD_ACT_PRIO8 ||
                          ci_transmit_register == l1b_pkg::CMD_ACT_PRIO10;
         prio10        <= ci_transmit_register == l1b_pkg::CMD_ACT_PRIO10;
         cont_pulses   <= ci_transmit_register == l1b_pkg::CMD_CONT_ZEROS;
         single_pulses <= ci_transmit_register == l1b_pkg::CMD_SINGLE_ZEROS;
         sw_reset      <= ci_transmit_register == l1b_pkg::CMD_RESET;
         loop3_active  <= ci_transmit_register == l1b_pkg::CMD_ACT_LOOP3;
      end
   end

   assign activated = act_req && line_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bchan_enable <= 1'b0;
      end else begin
         // second bus mode wants the activate command to stay written
         bchan_enable <= activated && (act_req || !bus_mode_select);
      end
   end

   // test pulses: one shared divider, polarity alternates per pulse
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pulse_cnt      <= 13'h0000;
         pulse_phase    <= 1'b0;
         line_pulse_pos <= 1'b0;
         line_pulse_neg <= 1'b0;
      end else if (!(cont_pulses || single_pulses)) begin
         pulse_cnt      <= 13'h0000;
         line_pulse_pos <= 1'b0;
         line_pulse_neg <= 1'b0;
      end else if (pulse_cnt == (cont_pulses ? 13'(CONT_PERIOD - 1)
                                             : 13'(SINGLE_PERIOD - 1))) begin
         pulse_cnt      <= 13'h0000;
         pulse_phase    <= ~pulse_phase;
         line_pulse_pos <= ~pulse_phase;
         line_pulse_neg <= pulse_phase;
      end else begin
         pulse_cnt      <= pulse_cnt + 13'h0001;
         line_pulse_pos <= 1'b0;
         line_pulse_neg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // indication and change flag
   // -------------------------------------------------------------------
   always_comb begin
      indication = l1b_pkg::IND_POWERED_UP;
      if (pwr_state != l1b_pkg::PWR_ACTIVE) begin
         indication = l1b_pkg::IND_DEACT_DOWN;
      end else if (sw_reset) begin
         indication = l1b_pkg::IND_ERROR;
      end else if (loop3_active || cont_pulses) begin
         indication = l1b_pkg::IND_TEST;
      end else if (activated) begin
         indication = prio10 ? l1b_pkg::IND_ACT_PRIO10 : l1b_pkg::IND_ACT_PRIO8;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ci_receive_register <= l1b_pkg::IND_POWERED_UP;
         ci_sq_change_irq    <= 1'b0;
      end else begin
         ci_receive_register <= indication;
         // a new change beats the clearing read in the same cycle
         if (indication != ci_receive_register || (nt_request == 1'b0 &&
             (op_mode == l1b_pkg::MODE_NT) && line_q && !timing_present)) begin
            ci_sq_change_irq <= 1'b1;
         end else if (rd_ci_rx) begin
            ci_sq_change_irq <= 1'b0;
         end
      end
   end

   assign ci_sq_change_irq_pending = ci_sq_change_irq && !irq_mask;

   // open-drain interrupt pin, follows bit_clock rise while clocks run
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_line_out  <= 1'b0;
         irq_line_oe_b <= 1'b1;
      end else if (rise || bus_stopped) begin
         irq_line_out  <= 1'b0;
         irq_line_oe_b <= !ci_sq_change_irq_pending;
      end
   end

   // -------------------------------------------------------------------
   // bus data and framing outputs
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_sync           <= 1'b0;
         bus_clock_drive      <= 1'b0;
         upstream_data_line   <= 1'b1;
         downstream_data_line <= 1'b1;
      end else begin
         bus_clock_drive <= te_mode;
         if (software_power_up) begin
            upstream_data_line <= 1'b0;
         end else if (rise && next_idx >= 5'(l1b_pkg::CI0_FIRST) &&
                      next_idx <= 5'(l1b_pkg::CI0_LAST)) begin
            // command code sent again in every frame, msb first
            upstream_data_line <= ci_transmit_register[
               2'(l1b_pkg::CI0_LAST - 32'(next_idx))];
         end else if (rise || bus_stopped) begin
            upstream_data_line <= 1'b1;
         end
         if (nt_request) begin
            downstream_data_line <= 1'b0;
         end else if (rise && next_idx >= 5'(l1b_pkg::CI0_FIRST) &&
                      next_idx <= 5'(l1b_pkg::CI0_LAST)) begin
            downstream_data_line <= indication[
               2'(l1b_pkg::CI0_LAST - 32'(next_idx))];
         end else if (rise || bus_stopped) begin
            downstream_data_line <= 1'b1;
         end
         if (rise) begin
            frame_sync <= te_mode && (next_idx == 5'h0);
         end else if (!clk_run) begin
            frame_sync <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // register reads: data in the cycle after the strobe
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         if (addr == l1b_pkg::REG_CTRL) begin
            rd_data <= {3'h0, op_mode, bus_mode_select, software_power_up,
                        clock_off_select};
         end else if (addr == l1b_pkg::REG_CI_TX) begin
            rd_data <= {4'h0, ci_transmit_register};
         end else if (addr == l1b_pkg::REG_CI_RX) begin
            rd_data <= {3'h0, ci_sq_change_irq, ci_receive_register};
         end else if (addr == l1b_pkg::REG_IRQ_STATUS) begin
            rd_data <= {4'h0, pwr_state, nt_request, ci_sq_change_irq};
         end else if (addr == l1b_pkg::REG_MASK) begin
            rd_data <= {7'h00, irq_mask};
         end else if (addr == l1b_pkg::REG_TEST_STATUS) begin
            rd_data <= {bchan_enable, activated, prio10, loop3_active, sw_reset,
                        single_pulses, cont_pulses, osc_enable};
         end else begin
            rd_data <= 8'h00;
         end
      end else begin
         rd_data <= 8'h00;
      end
   end
endmodule : l1b_core

/* tb/l1b_far_end.sv */
// Purpose: upstream unit giving bus timing in network mode
// Assumes: 800 ns bit period, 32-bit frame
// Notes:   clock stands low while run is 0; the bench never drops run
`timescale 1ns/100ps
module l1b_far_end (
   input  wire logic run,
   output logic      bit_clock_in,
   output logic      frame_sync_in
);
   int n = 0;
   initial bit_clock_in = 1'b0;
   initial frame_sync_in = 1'b0;
   always #400 begin
      bit_clock_in = run && !bit_clock_in;
      if (bit_clock_in) n = (n + 1) % 32;
      frame_sync_in = run && (n == 0);
   end
endmodule : l1b_far_end

/* tb/l1b_core_asserts.sv */
// Purpose: port checks for l1b_core
// Assumes: bench shortens pulse periods to 10 clk or more
// Notes:   one clock domain
`timescale 1ns/100ps
module l1b_core_asserts (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   input wire logic       bit_clock,
   input wire logic       frame_sync,
   input wire logic       upstream_data_line,
   input wire logic       downstream_data_line,
   input wire logic       irq_line_out,
   input wire logic       osc_enable,
   input wire logic       line_pulse_pos,
   input wire logic       line_pulse_neg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_half; bit_clock[*4] ##1 !bit_clock; endsequence
   sequence s_quiet; (!line_pulse_pos && !line_pulse_neg)[*8]; endsequence
   AST_BCLK_HALF: assert property ($rose(bit_clock) |-> s_half)
      else $error("bit clock high phase wrong");
   AST_FS_EDGE: assert property ($rose(frame_sync) |-> $rose(bit_clock))
      else $error("frame sync off bit edge");
   AST_FS_LEN: assert property ($rose(frame_sync) |-> frame_sync[*8] ##1 !frame_sync)
      else $error("frame sync length wrong");
   AST_DOWN_IDLE: assert property (!osc_enable |-> !bit_clock && upstream_data_line
      && downstream_data_line) else $error("idle bus levels wrong");
   AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data outside slot");
   AST_IRQ_OD: assert property (irq_line_out == 1'b0)
      else $error("irq data not low");
   AST_PULSE_EXCL: assert property (!(line_pulse_pos && line_pulse_neg))
      else $error("both pulses at once");
   AST_PULSE_GAP: assert property (line_pulse_pos || line_pulse_neg |=> s_quiet)
      else $error("pulses too close");
endmodule : l1b_core_asserts

/* tb/l1b_core_bench.sv */
// Purpose: self-checking bench for l1b_core
// Assumes: shortened restart and pulse periods
// Notes:   registers polled with bounded retries
`timescale 1ns/100ps
module l1b_core_bench;
   logic clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, line_signal = 0, run = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00, rd_data;
   logic bit_clock_in, frame_sync_in, bit_clock, frame_sync, bus_clock_drive, osc_enable;
   logic upstream_data_line, downstream_data_line, irq_line_out, irq_line_oe_b;
   logic line_pulse_pos, line_pulse_neg, loop3_active, bchan_enable;
   int err_total = 0, samples_checked = 0, cyc = 0;
   always #50 clk = !clk;
   l1b_core #(.RESTART_CYCLES(20), .SINGLE_PERIOD(50), .CONT_PERIOD(10)) uut (.*);
   l1b_far_end far (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic pr(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         addr <= a;
         rd_en <= 1'b1;
         @(posedge clk);
         rd_en <= 1'b0;
         #1 v = rd_data & m;
         if (v === e) break;
      end
      chk(v, e);
   endtask : pr
   task automatic wt(ref logic s, input logic v);
      for (int i = 0; i < 5000 && s !== v; i++) @(posedge clk);
      chk({7'h00, s}, {7'h00, v});
   endtask : wt
   task automatic t_reset;
      pr(l1b_pkg::REG_CTRL, 8'hFF, 8'h00);
      pr(l1b_pkg::REG_CI_TX, 8'h0F, 8'h0F);
      pr(4'hF, 8'hFF, 8'h00);
   endtask : t_reset
   task automatic t_deact;
      wr(l1b_pkg::REG_CTRL, 8'h01);
      wt(osc_enable, 1'b0);
      chk({bit_clock, downstream_data_line}, 8'h01);
      pr(l1b_pkg::REG_CI_RX, 8'h0F, 8'h0F);
      pr(l1b_pkg::REG_IRQ_STATUS, 8'h0C, 8'h0C);
   endtask : t_deact
   task automatic t_restart;
      wr(l1b_pkg::REG_CI_TX, 8'h00);
      wt(bit_clock, 1'b1);
      repeat (15) @(posedge clk);
      chk({7'h00, frame_sync}, 8'h00);
      @(posedge clk);
      chk({7'h00, frame_sync}, 8'h01);
      pr(l1b_pkg::REG_CI_RX, 8'h0F, 8'h07);
      wr(l1b_pkg::REG_CTRL, 8'h02);
      wt(upstream_data_line, 1'b0);
      wr(l1b_pkg::REG_CTRL, 8'h00);
      wt(upstream_data_line, 1'b1);
   endtask : t_restart
   task automatic t_cmds;
      logic [7:0] cm [5] = '{8'h01, 8'h04, 8'h02, 8'h0A, 8'h09};
      logic [7:0] bm [5] = '{8'h08, 8'h02, 8'h04, 8'h10, 8'h20};
      wr(l1b_pkg::REG_CTRL, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(l1b_pkg::REG_CI_TX, cm[k]);
         pr(l1b_pkg::REG_TEST_STATUS, bm[k], bm[k]);
         if (k == 3) chk({7'h00, loop3_active}, 8'h01);
      end
   endtask : t_cmds
   task automatic t_nt;
      // leave terminal mode in a low phase so no clock pulse is cut
      wt(bit_clock, 1'b1);
      wt(bit_clock, 1'b0);
      wr(l1b_pkg::REG_CTRL, 8'h08);
      line_signal <= 1'b1;
      wt(downstream_data_line, 1'b0);
      pr(l1b_pkg::REG_IRQ_STATUS, 8'h02, 8'h02);
      run <= 1'b1;
      wt(downstream_data_line, 1'b1);
   endtask : t_nt
   task automatic t_mask;
      wr(l1b_pkg::REG_MASK, 8'hFF);
      repeat (20) @(posedge clk);
      chk({7'h00, irq_line_oe_b}, 8'h01);
      pr(l1b_pkg::REG_MASK, 8'hFF, 8'h01);
      wr(l1b_pkg::REG_MASK, 8'h00);
      repeat (20) @(posedge clk);
      chk({7'h00, irq_line_oe_b}, 8'h00);
      pr(l1b_pkg::REG_CI_RX, 8'h10, 8'h10);
      repeat (20) @(posedge clk);
      chk({7'h00, irq_line_oe_b}, 8'h01);
   endtask : t_mask
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   always @(posedge clk) if (++cyc == 60000) begin
      err_total++;
      final_report;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_deact;
      t_restart;
      t_cmds;
      t_nt;
      t_mask;
      final_report;
   end
endmodule : l1b_core_bench
bind l1b_core l1b_core_asserts chk (.*);
